// File: core/pmux_top.sv
// Operation
// - Port A bit 0: analog 0, then timer channel 0, keypad 0, port.
// - Port A bit 1: analog 1, then timer channel 1, keypad 1, port.
// - Port A bit 2: external interrupt, then timer clock, keypad 2, port.
// - Port A bit 3: reset input, then keypad 3, then port.
// - Port A bit 4: oscillator output, then analog 2, keypad 4, port.
// - Port A bit 5: oscillator input, then analog 3, keypad 5, port.
// - Port B bits 0 and 1 carry analog 4 and 5 ahead of port.
// - At reset every pin is a port input, whatever else is enabled.
// - Analog selection never steals pin control or forces port direction.
// - Port A bit 2 is input only; the port never drives it.
// - Bit 4 drives crystal output, or internal clock when output enable set.
// - Bit 5 feeds the oscillator input when the oscillator claims it.
// - Timer channel pins are bidirectional: capture in or compare out.
// - Per-bit pull-ups; reset and interrupt pins get pull-ups too.
// - Reset input is active low through a Schmitt input on bit 3.
// - Port B bits 2 to 7 are plain bidirectional port bits.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module pmux_top (
  input  wire logic                        SYS_CLK,       // System bus clock
  input  wire logic                        RST,           // Async reset, high
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  input  wire logic [pmux_pkg::ADDR_W-1:0] S_AXI_AWADDR,  // Write address
  input  wire logic                        S_AXI_AWVALID, // Write address valid
  output logic                             S_AXI_AWREADY, // Write address ready
  input  wire logic [pmux_pkg::DATA_W-1:0] S_AXI_WDATA,   // Write data
  input  wire logic [3:0]                  S_AXI_WSTRB,   // Byte strobes
  input  wire logic                        S_AXI_WVALID,  // Write data valid
  output logic                             S_AXI_WREADY,  // Write data ready
  output logic [1:0]                       S_AXI_BRESP,   // Write response
  output logic                             S_AXI_BVALID,  // Write response valid
  input  wire logic                        S_AXI_BREADY,  // Write response ready
  input  wire logic [pmux_pkg::ADDR_W-1:0] S_AXI_ARADDR,  // Read address
  input  wire logic                        S_AXI_ARVALID, // Read address valid
  output logic                             S_AXI_ARREADY, // Read address ready
  output logic [pmux_pkg::DATA_W-1:0]      S_AXI_RDATA,   // Read data
  output logic [1:0]                       S_AXI_RRESP,   // Read response
  output logic                             S_AXI_RVALID,  // Read data valid
  input  wire logic                        S_AXI_RREADY,  // Read data ready
  // ----------------------------------------------------------------
  // Peripheral side
  // ----------------------------------------------------------------
  input  wire logic [5:0]                  ADC_CH_EN,     // Analog channel selects
  input  wire logic [1:0]                  TIM_CH_EN,     // Timer channel enables
  input  wire logic [1:0]                  TIM_CH_OE,     // Timer compare drive
  input  wire logic [1:0]                  TIM_CH_OUT,    // Timer compare value
  input  wire logic                        TIM_XCLK_EN,   // Timer ext clock enable
  input  wire logic [5:0]                  KBI_EN,        // Keypad input enables
  input  wire logic                        IRQ_EN,        // External irq enable
  input  wire logic                        RSTPIN_EN,     // Reset pin enable
  input  wire logic                        OSC_IN_EN,     // Oscillator uses bit 5
  input  wire logic                        XTAL_MODE,     // Crystal mode
  input  wire logic                        XTAL_DRIVE,    // Crystal amplifier out
  input  wire logic                        INT_OSC_CLK,   // RC or internal clock
  output logic [5:0]                       ADC_OWN,       // Analog owns channel
  output logic [1:0]                       TIM_CAP_IN,    // Capture inputs
  output logic                             TIM_XCLK_IN,   // Timer clock input
  output logic [5:0]                       KBI_IN,        // Keypad inputs
  output logic                             IRQ_IN_N,      // Interrupt, low
  output logic                             RESET_IN_N,    // Reset request, low
  output logic                             OSC_IN,        // Oscillator input
  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  input  wire logic [5:0]                  PA_IN,         // Port A pin levels
  output logic [5:0]                       PA_OUT,        // Port A drive value
  output logic [5:0]                       PA_OE,         // Port A drive enable
  output logic [5:0]                       PA_PULLUP,     // Port A pull-ups
  output logic [5:0]                       PA_SCHMITT,    // Port A Schmitt select
  input  wire logic [7:0]                  PB_IN,         // Port B pin levels
  output logic [7:0]                       PB_OUT,        // Port B drive value
  output logic [7:0]                       PB_OE,         // Port B drive enable
  output logic [7:0]                       PB_PULLUP      // Port B pull-ups
);

  pmux_reg_if rif ();

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  pmux_axil_slave u_bus (
    .clk     (SYS_CLK),
    .rst     (RST),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .rif     (rif.bus)
  );

  function automatic logic addr_ok(input logic [pmux_pkg::ADDR_W-1:0] a);
    return a == pmux_pkg::PA_DATA_OFS || a == pmux_pkg::PA_DIR_OFS ||
           a == pmux_pkg::PA_PULL_OFS || a == pmux_pkg::PB_DATA_OFS ||
           a == pmux_pkg::PB_DIR_OFS  || a == pmux_pkg::PB_PULL_OFS ||
           a == pmux_pkg::PIN_STAT_OFS || a == pmux_pkg::OWN_STAT_OFS;
  endfunction : addr_ok

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [5:0] pa_data_q, pa_data_d;
  logic [5:0] pa_dir_q, pa_dir_d;
  logic [5:0] pa_pull_q, pa_pull_d;
  logic [7:0] pb_data_q, pb_data_d;
  logic [7:0] pb_dir_q, pb_dir_d;
  logic [7:0] pb_pull_q, pb_pull_d;
  logic       osc_output_enable_q, osc_output_enable_d;
  logic       wr_hit;
  logic [7:0] wbyte;
  logic [5:0] port_own;
  logic [5:0] adc_own;

  assign wr_hit     = rif.wr_en & rif.wr_strb[0];
  assign wbyte      = rif.wr_data[7:0];
  assign rif.wr_err = ~addr_ok(rif.wr_addr);

  always_comb begin
    pa_data_d = pa_data_q;
    pa_dir_d = pa_dir_q;
    pa_pull_d = pa_pull_q;
    pb_data_d = pb_data_q;
    pb_dir_d = pb_dir_q;
    pb_pull_d = pb_pull_q;
    osc_output_enable_d = osc_output_enable_q;
    if (wr_hit) begin
      unique case (rif.wr_addr)
        pmux_pkg::PA_DATA_OFS: pa_data_d = wbyte[5:0];
        pmux_pkg::PA_DIR_OFS:  pa_dir_d  = wbyte[5:0] & pmux_pkg::PA_DIR_WMASK;
        pmux_pkg::PA_PULL_OFS: begin
          pa_pull_d           = wbyte[5:0];
          osc_output_enable_d = wbyte[pmux_pkg::OSC_OUT_EN_BIT];
        end
        pmux_pkg::PB_DATA_OFS: pb_data_d = wbyte;
        pmux_pkg::PB_DIR_OFS:  pb_dir_d  = wbyte;
        pmux_pkg::PB_PULL_OFS: pb_pull_d = wbyte;
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pa_data_q <= pmux_pkg::PA_RST;
      pa_dir_q <= pmux_pkg::PA_RST;
      pa_pull_q <= pmux_pkg::PA_RST;
      pb_data_q <= pmux_pkg::PB_RST;
      pb_dir_q <= pmux_pkg::PB_RST;
      pb_pull_q <= pmux_pkg::PB_RST;
      osc_output_enable_q <= pmux_pkg::OSC_OUT_EN_RST;
    end else begin
      pa_data_q <= pa_data_d;
      pa_dir_q <= pa_dir_d;
      pa_pull_q <= pa_pull_d;
      pb_data_q <= pb_data_d;
      pb_dir_q <= pb_dir_d;
      pb_pull_q <= pb_pull_d;
      osc_output_enable_q <= osc_output_enable_d;
    end
  end

  // Data reads show the latch on outputs and the pin level on inputs
  always_comb begin
    rif.rd_data = '0;
    rif.rd_err  = ~addr_ok(rif.rd_addr);
    unique case (rif.rd_addr)
      pmux_pkg::PA_DATA_OFS:  rif.rd_data[5:0] = (pa_dir_q & pa_data_q) | (~pa_dir_q & PA_IN);
      pmux_pkg::PA_DIR_OFS:   rif.rd_data[5:0] = pa_dir_q;
      pmux_pkg::PA_PULL_OFS:  rif.rd_data[7:0] = {osc_output_enable_q, 1'b0, pa_pull_q};
      pmux_pkg::PB_DATA_OFS:  rif.rd_data[7:0] = (pb_dir_q & pb_data_q) | (~pb_dir_q & PB_IN);
      pmux_pkg::PB_DIR_OFS:   rif.rd_data[7:0] = pb_dir_q;
      pmux_pkg::PB_PULL_OFS:  rif.rd_data[7:0] = pb_pull_q;
      pmux_pkg::PIN_STAT_OFS: rif.rd_data[15:0] = {PB_IN, 2'b00, PA_IN};
      pmux_pkg::OWN_STAT_OFS: rif.rd_data[13:0] = {port_own, 2'b00, adc_own};
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // Port A priority resolution
  // ----------------------------------------------------------------
  // Analog selection sits above every slot except the oscillator slots on bits 4 and 5, but is left out of the drive
  // arbitration, so it never takes the pin from a lower sharer.
  logic [3:0] cand_en  [6];
  logic [3:0] cand_drv [6];
  logic [3:0] cand_oe  [6];
  logic [3:0] sel      [6];
  logic [5:0] res_out;
  logic [5:0] res_oe;
  logic       osc_out_claim;

  assign osc_out_claim = XTAL_MODE | osc_output_enable_q;

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      cand_en[i]  = {1'b1, 3'b000};
      cand_drv[i] = {pa_data_q[i], 3'b000};
      cand_oe[i]  = {pa_dir_q[i], 3'b000};
    end
    cand_en[0][1:0]  = {KBI_EN[0], TIM_CH_EN[0]};
    cand_drv[0][0]   = TIM_CH_OUT[0];
    cand_oe[0][0]    = TIM_CH_OE[0];
    cand_en[1][1:0]  = {KBI_EN[1], TIM_CH_EN[1]};
    cand_drv[1][0]   = TIM_CH_OUT[1];
    cand_oe[1][0]    = TIM_CH_OE[1];
    cand_en[2][2:0]  = {KBI_EN[2], TIM_XCLK_EN, IRQ_EN};
    cand_oe[2][3]    = 1'b0;
    cand_en[3][1:0]  = {KBI_EN[3], RSTPIN_EN};
    cand_en[4][1:0]  = {KBI_EN[4], osc_out_claim};
    cand_drv[4][0]   = osc_output_enable_q ? INT_OSC_CLK : XTAL_DRIVE;
    cand_oe[4][0]    = 1'b1;
    cand_en[5][1:0]  = {KBI_EN[5], OSC_IN_EN};
  end

  for (genvar g = 0; g < 6; g++) begin : g_pa
    pmux_prio_cell #(.N(pmux_pkg::SLOT_N)) u_cell (
      .en      (cand_en[g]),
      .drv     (cand_drv[g]),
      .oe      (cand_oe[g]),
      .sel     (sel[g]),
      .pin_out (res_out[g]),
      .pin_oe  (res_oe[g])
    );
    assign port_own[g] = sel[g][3];
  end

  assign adc_own = {ADC_CH_EN[5:4],
                    ADC_CH_EN[3] & ~sel[5][0],
                    ADC_CH_EN[2] & ~sel[4][0],
                    ADC_CH_EN[1:0]};

  // ----------------------------------------------------------------
  // Registered pin and peripheral outputs
  // ----------------------------------------------------------------
  logic [5:0] pa_out_d;
  logic [5:0] pa_oe_d;
  logic [5:0] pa_pu_d;
  logic [5:0] pa_st_d;
  logic [5:0] kbi_d;
  logic [7:0] pb_out_d;
  logic [7:0] pb_oe_d;
  logic [7:0] pb_pu_d;
  logic [1:0] cap_d;
  logic       tim_xclk_d;
  logic       irq_n_d;
  logic       rst_n_d;
  logic       osc_d;
  logic [5:0] kbi_own;

  // Bit 2 keypad slot sits behind interrupt and timer clock
  assign kbi_own = {sel[5][1], sel[4][1], sel[3][1],
                    sel[2][2], sel[1][1], sel[0][1]};

  always_comb begin
    pa_out_d = res_out;
    pa_oe_d  = res_oe;
    pa_pu_d  = pa_pull_q;
    pa_pu_d[2] = pa_pull_q[2] | sel[2][0];
    pa_pu_d[3] = pa_pull_q[3] | sel[3][0];
    pa_st_d  = 6'h00;
    pa_st_d[2] = sel[2][0];
    pa_st_d[3] = sel[3][0];
    kbi_d    = (PA_IN & kbi_own) | ~kbi_own;
    cap_d    = {sel[1][0] ? PA_IN[1] : 1'b0, sel[0][0] ? PA_IN[0] : 1'b0};
    tim_xclk_d = sel[2][1] & PA_IN[2];
    irq_n_d  = ~sel[2][0] | PA_IN[2];
    rst_n_d  = ~sel[3][0] | PA_IN[3];
    osc_d    = sel[5][0] & PA_IN[5];
    pb_out_d = pb_data_q;
    pb_oe_d  = pb_dir_q;
    pb_pu_d  = pb_pull_q;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PA_OUT <= 6'h00;
      PA_OE <= 6'h00;
      PA_PULLUP <= 6'h00;
      PA_SCHMITT <= 6'h00;
      PB_OUT <= 8'h00;
      PB_OE <= 8'h00;
      PB_PULLUP <= 8'h00;
      ADC_OWN <= 6'h00;
      KBI_IN <= 6'h3f;
      TIM_CAP_IN <= 2'h0;
      TIM_XCLK_IN <= 1'b0;
      IRQ_IN_N <= 1'b1;
      RESET_IN_N <= 1'b1;
      OSC_IN <= 1'b0;
    end else begin
      PA_OUT <= pa_out_d;
      PA_OE <= pa_oe_d;
      PA_PULLUP <= pa_pu_d;
      PA_SCHMITT <= pa_st_d;
      PB_OUT <= pb_out_d;
      PB_OE <= pb_oe_d;
      PB_PULLUP <= pb_pu_d;
      ADC_OWN <= adc_own;
      KBI_IN <= kbi_d;
      TIM_CAP_IN <= cap_d;
      TIM_XCLK_IN <= tim_xclk_d;
      IRQ_IN_N <= irq_n_d;
      RESET_IN_N <= rst_n_d;
      OSC_IN <= osc_d;
    end
  end

endmodule : pmux_top

// File: core/pmux_pkg.sv
package pmux_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PA_W   = 6;
  localparam int PB_W   = 8;
  localparam int SLOT_N = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PA_DATA_OFS  = 8'h00;
  localparam logic [7:0] PA_DIR_OFS   = 8'h04;
  localparam logic [7:0] PA_PULL_OFS  = 8'h08;
  localparam logic [7:0] PB_DATA_OFS  = 8'h0c;
  localparam logic [7:0] PB_DIR_OFS   = 8'h10;
  localparam logic [7:0] PB_PULL_OFS  = 8'h14;
  localparam logic [7:0] PIN_STAT_OFS = 8'h18;
  localparam logic [7:0] OWN_STAT_OFS = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int         OSC_OUT_EN_BIT = 7;
  localparam int         PB_STAT_LSB    = 8;
  localparam int         PORT_OWN_LSB   = 8;
  localparam logic [5:0] PA_DIR_WMASK   = 6'h3b;
  localparam logic [5:0] PA_RST         = 6'h00;
  localparam logic [7:0] PB_RST         = 8'h00;
  localparam logic       OSC_OUT_EN_RST = 1'h0;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pmux_pkg

// File: core/pmux_reg_if.sv
`timescale 1ns/1ps
interface pmux_reg_if;
  logic                        wr_en;
  logic [pmux_pkg::ADDR_W-1:0] wr_addr;
  logic [pmux_pkg::DATA_W-1:0] wr_data;
  logic [3:0]                  wr_strb;
  logic                        wr_err;
  logic                        rd_en;
  logic [pmux_pkg::ADDR_W-1:0] rd_addr;
  logic [pmux_pkg::DATA_W-1:0] rd_data;
  logic                        rd_err;

  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                input  wr_err, rd_data, rd_err);
  modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface : pmux_reg_if

// File: core/pmux_prio_cell.sv
`timescale 1ns/1ps
module pmux_prio_cell #(
  parameter int N = 4
) (
  input  wire logic [N-1:0] en,      // Candidate enables, bit 0 highest
  input  wire logic [N-1:0] drv,     // Candidate output values
  input  wire logic [N-1:0] oe,      // Candidate output enables
  output logic      [N-1:0] sel,     // One-hot winner
  output logic              pin_out, // Winner's output value
  output logic              pin_oe   // Winner's output enable
);

  logic found;

  always_comb begin
    sel   = '0;
    found = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (en[i] && !found) begin
        sel[i] = 1'b1;
        found  = 1'b1;
      end
    end
    pin_out = |(sel & drv);
    pin_oe  = |(sel & oe);
  end

endmodule : pmux_prio_cell

// File: core/pmux_axil_slave.sv
`timescale 1ns/1ps
module pmux_axil_slave (
  input  wire logic                        clk,     // System clock
  input  wire logic                        rst,     // Async reset, high
  input  wire logic [pmux_pkg::ADDR_W-1:0] awaddr,  // Write address
  input  wire logic                        awvalid, // Write address valid
  output logic                             awready, // Write address ready
  input  wire logic [pmux_pkg::DATA_W-1:0] wdata,   // Write data
  input  wire logic [3:0]                  wstrb,   // Byte strobes
  input  wire logic                        wvalid,  // Write data valid
  output logic                             wready,  // Write data ready
  output logic [1:0]                       bresp,   // Write response
  output logic                             bvalid,  // Write response valid
  input  wire logic                        bready,  // Write response ready
  input  wire logic [pmux_pkg::ADDR_W-1:0] araddr,  // Read address
  input  wire logic                        arvalid, // Read address valid
  output logic                             arready, // Read address ready
  output logic [pmux_pkg::DATA_W-1:0]      rdata,   // Read data
  output logic [1:0]                       rresp,   // Read response
  output logic                             rvalid,  // Read data valid
  input  wire logic                        rready,  // Read data ready
  pmux_reg_if.bus                          rif      // Register access
);

  logic                        aw_q, aw_d, w_q, w_d;
  logic [pmux_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [pmux_pkg::DATA_W-1:0] wdata_q, wdata_d, rdata_d;
  logic [3:0]                  wstrb_q, wstrb_d;
  logic                        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]                  bresp_d, rresp_d;

  assign rif.wr_addr = awaddr_q;
  assign rif.wr_data = wdata_q;
  assign rif.wr_strb = wstrb_q;
  assign rif.wr_en   = aw_q & w_q & ~bvalid;
  assign rif.rd_addr = araddr;
  assign rif.rd_en   = arvalid & arready;

  always_comb begin
    aw_d = aw_q; w_d = w_q; awaddr_d = awaddr_q; wdata_d = wdata_q; wstrb_d = wstrb_q;
    bvalid_d = bvalid; bresp_d = bresp; rvalid_d = rvalid; rdata_d = rdata; rresp_d = rresp;
    // Address and data may arrive in either order
    if (awvalid && awready) begin
      aw_d     = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_d     = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (rif.wr_en) begin
      aw_d     = 1'b0;
      w_d      = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = rif.wr_err ? pmux_pkg::RESP_SLVERR : pmux_pkg::RESP_OKAY;
    end else if (bvalid && bready) begin
      bvalid_d = 1'b0;
    end
    if (rif.rd_en) begin
      rvalid_d = 1'b1;
      rdata_d  = rif.rd_data;
      rresp_d  = rif.rd_err ? pmux_pkg::RESP_SLVERR : pmux_pkg::RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid_d = 1'b0;
    end
    awready_d = ~aw_d & ~bvalid_d;
    wready_d  = ~w_d & ~bvalid_d;
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_q <= 1'b0; w_q <= 1'b0; awaddr_q <= '0; wdata_q <= '0; wstrb_q <= '0;
      awready <= 1'b0; wready <= 1'b0; bvalid <= 1'b0; bresp <= pmux_pkg::RESP_OKAY;
      arready <= 1'b0; rvalid <= 1'b0; rdata <= '0; rresp <= pmux_pkg::RESP_OKAY;
    end else begin
      aw_q <= aw_d; w_q <= w_d; awaddr_q <= awaddr_d; wdata_q <= wdata_d; wstrb_q <= wstrb_d;
      awready <= awready_d; wready <= wready_d; bvalid <= bvalid_d; bresp <= bresp_d;
      arready <= arready_d; rvalid <= rvalid_d; rdata <= rdata_d; rresp <= rresp_d;
    end
  end

endmodule : pmux_axil_slave

// File: verif/pmux_checker.sv
`timescale 1ns/1ps
module pmux_checker (
  input wire logic       SYS_CLK,    // Clock
  input wire logic       RST,        // Reset
  input wire logic [1:0] TIM_CH_EN,  // Timer enables
  input wire logic [1:0] TIM_CH_OE,  // Timer drive
  input wire logic [1:0] TIM_CH_OUT, // Timer value
  input wire logic [5:0] KBI_EN,     // Keypad enables
  input wire logic       IRQ_EN,     // Irq enable
  input wire logic       RSTPIN_EN,  // Reset pin enable
  input wire logic       OSC_IN_EN,  // Osc input enable
  input wire logic       XTAL_MODE,  // Crystal mode
  input wire logic [5:0] ADC_CH_EN,  // Analog selects
  input wire logic [5:0] ADC_OWN,    // Analog owns
  input wire logic [5:0] PA_IN,      // Pin levels
  input wire logic [5:0] PA_OUT,     // Drive value
  input wire logic [5:0] PA_OE,      // Drive enable
  input wire logic [5:0] PA_PULLUP,  // Pull-ups
  input wire logic [5:0] PA_SCHMITT, // Schmitt select
  input wire logic       IRQ_IN_N,   // Irq in
  input wire logic       RESET_IN_N, // Reset in
  input wire logic       OSC_IN      // Osc in
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  chk_pa2_input: assert property (!PA_OE[2]) else $error("Port A bit 2 driven");
  chk_reset_idle: assert property ($fell(RST) |-> PA_OE == 6'h00)
    else $error("Pin driven out of reset");
  chk_tim_owns: assert property (TIM_CH_EN[0] |=> PA_OE[0] == $past(TIM_CH_OE[0])
    && (!PA_OE[0] || PA_OUT[0] == $past(TIM_CH_OUT[0]))) else $error("Timer lost bit 0");
  chk_kbi_input: assert property (KBI_EN[1] && !TIM_CH_EN[1] |=> !PA_OE[1])
    else $error("Keypad pin driven");
  chk_rst_pin: assert property (RSTPIN_EN |=> !PA_OE[3] && PA_PULLUP[3] && PA_SCHMITT[3]
    && RESET_IN_N == $past(PA_IN[3])) else $error("Reset pin wrong");
  chk_irq_pin: assert property (IRQ_EN |=> PA_PULLUP[2] && PA_SCHMITT[2]
    && IRQ_IN_N == $past(PA_IN[2])) else $error("Irq pin wrong");
  chk_osc_drive: assert property (XTAL_MODE |=> PA_OE[4] && !ADC_OWN[2])
    else $error("Osc output lost bit 4");
  chk_osc_in: assert property (OSC_IN_EN |=> !PA_OE[5] && !ADC_OWN[3]
    && OSC_IN == $past(PA_IN[5])) else $error("Osc input wrong");
  chk_adc_owns: assert property (1'b1 |=> ADC_OWN[1:0] == $past(ADC_CH_EN[1:0])
    && ADC_OWN[5:4] == $past(ADC_CH_EN[5:4])) else $error("Analog ownership wrong");
  cover property (TIM_CH_EN[0] && TIM_CH_OE[0]);
  cover property (RSTPIN_EN && IRQ_EN);
  cover property (XTAL_MODE && OSC_IN_EN);
endmodule : pmux_checker
bind pmux_top pmux_checker chk_u (.*);

// File: verif/pmux_board.sv
`timescale 1ns/1ps
module pmux_board #(
  parameter int W = 6
) (
  input  wire logic         clk,     // Clock
  input  wire logic [W-1:0] pad_out, // Device value
  input  wire logic [W-1:0] pad_oe,  // Device drive
  input  wire logic [W-1:0] pad_pu,  // Pull-ups
  input  wire logic [W-1:0] ext_en,  // Board drive
  input  wire logic [W-1:0] ext_val, // Board value
  output logic      [W-1:0] pad_in   // Pin level
);
  // Floating pins wander so stale levels never pass
  logic [W-1:0] flt_q = '0;
  always_ff @(posedge clk) flt_q <= ~flt_q;
  assign pad_in = pad_oe & pad_out | ~pad_oe & (ext_en & ext_val | ~ext_en & (pad_pu | flt_q));
endmodule : pmux_board

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic SYS_CLK = 0, RST = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
  logic S_AXI_RREADY = 0, TIM_XCLK_EN = 0, IRQ_EN = 0, RSTPIN_EN = 0, OSC_IN_EN = 0, XTAL_MODE = 0;
  logic XTAL_DRIVE = 0, INT_OSC_CLK = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, TIM_XCLK_IN, IRQ_IN_N, RESET_IN_N, OSC_IN;
  logic [7:0]  S_AXI_AWADDR = '0, S_AXI_ARADDR = '0, PB_IN, PB_OUT, PB_OE, PB_PULLUP;
  logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, rd_w;
  logic [3:0]  S_AXI_WSTRB = 4'hf;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, TIM_CH_EN = 2'h3, TIM_CH_OE = 2'h3, TIM_CH_OUT = '0, TIM_CAP_IN, rd_r, rd_b;
  logic [5:0]  ADC_CH_EN = 6'h3f, KBI_EN = '0, ADC_OWN, KBI_IN, PA_IN, PA_OUT, PA_OE, PA_PULLUP, PA_SCHMITT;
  logic [5:0]  pa_xe = '0, pa_xv = '0;
  int          err_count = 0, n_compared = 0;
  pmux_top dut_u (.*);
  pmux_board #(.W(6)) pa_u (.clk(SYS_CLK), .pad_out(PA_OUT), .pad_oe(PA_OE), .pad_pu(PA_PULLUP),
    .ext_en(pa_xe), .ext_val(pa_xv), .pad_in(PA_IN));
  pmux_board #(.W(8)) pb_u (.clk(SYS_CLK), .pad_out(PB_OUT), .pad_oe(PB_OE), .pad_pu(PB_PULLUP),
    .ext_en(8'h00), .ext_val(8'h00), .pad_in(PB_IN));
  always #5 SYS_CLK = ~SYS_CLK;
  task conclude;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task settle;
    repeat (3) @(posedge SYS_CLK);
    #1;
  endtask : settle
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a; S_AXI_WDATA <= d; S_AXI_AWVALID <= 1; S_AXI_WVALID <= 1; S_AXI_BREADY <= 1;
    while (S_AXI_BVALID !== 1'b1) begin
      @(posedge SYS_CLK);
      if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 0;
    end
    rd_b = S_AXI_BRESP; S_AXI_BREADY <= 0;
  endtask : axw
  task axr(input logic [7:0] a);
    @(posedge SYS_CLK);
    S_AXI_ARADDR <= a; S_AXI_ARVALID <= 1; S_AXI_RREADY <= 1;
    while (S_AXI_RVALID !== 1'b1) begin
      @(posedge SYS_CLK);
      if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 0;
    end
    rd_w = S_AXI_RDATA; rd_r = S_AXI_RRESP; S_AXI_RREADY <= 0;
  endtask : axr
  initial begin
    #50000;
    err_count++;
    conclude();
  end
  initial begin
    @(posedge SYS_CLK);
    #1 chk("pa_oe", 32'h0, PA_OE);
    chk("pb_oe", 32'h0, PB_OE);
    @(posedge SYS_CLK) RST <= 0;
    settle();
    chk("pa_oe_tim", 32'h3, PA_OE[1:0]);
    chk("adc_own", 32'h3f, ADC_OWN);
    $display("Test reset done");
    @(posedge SYS_CLK) {TIM_CH_OE, TIM_CH_OUT, KBI_EN, pa_xe, pa_xv} <= {2'h1, 2'h1, 6'h3f, 6'h02, 6'h02};
    settle();
    chk("pa_oe_cap", 32'h1, PA_OE[1:0]);
    chk("tim_out", 32'h1, PA_OUT[0]);
    chk("cap_in", 32'h1, TIM_CAP_IN[1]);
    @(posedge SYS_CLK) {TIM_CH_EN, TIM_XCLK_EN, pa_xe, pa_xv} <= {2'h1, 1'b1, 6'h3e, 6'h3c};
    settle();
    chk("kbi_in", 32'h3d, KBI_IN);
    chk("xclk_in", 32'h1, TIM_XCLK_IN);
    $display("Test timer done");
    @(posedge SYS_CLK) {TIM_CH_EN, TIM_XCLK_EN, KBI_EN, pa_xe} <= '0;
    axw(pmux_pkg::PA_DIR_OFS, 32'h3f);
    axw(pmux_pkg::PA_DATA_OFS, 32'h15);
    chk("wr_resp", pmux_pkg::RESP_OKAY, rd_b);
    settle();
    chk("pa_oe_port", 32'h3b, PA_OE);
    chk("pa_out_port", 32'h11, PA_OUT & 6'h3b);
    axr(pmux_pkg::PA_DIR_OFS);
    chk("pa_dir", 32'h3b, rd_w);
    axr(8'h40);
    chk("bad_resp", pmux_pkg::RESP_SLVERR, rd_r);
    axw(8'h40, 32'h0);
    chk("bad_wr", pmux_pkg::RESP_SLVERR, rd_b);
    $display("Test port done");
    @(posedge SYS_CLK) {RSTPIN_EN, IRQ_EN, pa_xe, pa_xv} <= {2'h3, 6'h0c, 6'h04};
    settle();
    chk("reset_in_n", 32'h0, RESET_IN_N);
    chk("irq_in_n", 32'h1, IRQ_IN_N);
    chk("pa_oe3", 32'h0, PA_OE[3]);
    chk("pullup", 32'h3, PA_PULLUP[3:2]);
    chk("schmitt", 32'h3, PA_SCHMITT[3:2]);
    $display("Test reset pin done");
    @(posedge SYS_CLK) {XTAL_MODE, XTAL_DRIVE, OSC_IN_EN, pa_xe, pa_xv} <= {3'h7, 6'h20, 6'h20};
    settle();
    chk("pa_oe_osc", 32'h1, PA_OE[5:4]);
    chk("xtal_out", 32'h1, PA_OUT[4]);
    chk("osc_in", 32'h1, OSC_IN);
    chk("adc_own_osc", 32'h0, ADC_OWN[3:2]);
    axw(pmux_pkg::PA_PULL_OFS, 32'h80);
    settle();
    chk("int_osc_out", 32'h0, PA_OUT[4]);
    $display("Test oscillator done");
    axw(pmux_pkg::PB_DIR_OFS, 32'hfc);
    axw(pmux_pkg::PB_DATA_OFS, 32'ha5);
    axw(pmux_pkg::PB_PULL_OFS, 32'h03);
    settle();
    chk("pb_oe", 32'hfc, PB_OE);
    chk("pb_out", 32'ha4, PB_OUT & 8'hfc);
    chk("pb_pull", 32'h03, PB_PULLUP);
    chk("adc_own_pb", 32'h3, ADC_OWN[5:4]);
    axr(pmux_pkg::PB_DATA_OFS);
    chk("pb_read", 32'ha7, rd_w);
    $display("Test port B done");
    conclude();
  end
endmodule : tb_top
